/* logic/phb_top.sv */
// phb_top: host bus interface, target and simple bus master
// assumes clk is the bus clock, bus inputs synchronous to it
`timescale 1ns/1ps
module phb_top #(
    parameter int unsigned SAW = 6
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] ad_in,
    output logic      [31:0] ad_out,
    output logic             ad_oe_b,
    input  wire logic [3:0]  cbe_n_in,
    output logic      [3:0]  cbe_n_out,
    output logic             cbe_oe_b,
    input  wire logic        par_in,
    output logic             par_out,
    output logic             par_oe_b,
    input  wire logic        frame_n_in,
    output logic             frame_n_out,
    output logic             frame_oe_b,
    input  wire logic        irdy_n_in,
    output logic             irdy_n_out,
    output logic             irdy_oe_b,
    output logic             trdy_n_out,
    output logic             trdy_oe_b,
    input  wire logic        trdy_n_in,
    input  wire logic        devsel_n_in,
    output logic             devsel_n_out,
    output logic             devsel_oe_b,
    input  wire logic        idsel,
    output logic             req_n,
    input  wire logic        gnt_n,
    output logic             inta_n_out,
    output logic             inta_oe_b,
    input  wire logic        secondary_drive_interrupt_in,
    input  wire logic        native_mode,
    input  wire logic        mst_start,
    input  wire logic        mst_write,
    input  wire logic [31:0] mst_addr,
    input  wire logic [31:0] mst_wdata,
    output logic             mst_busy,
    output logic             mst_done,
    output logic             mst_abort,
    output logic      [31:0] mst_rdata
);
    phb_pkg::phb_state_t state;
    phb_pkg::phb_state_t next_state;
    logic        t_write;
    logic        next_t_write;
    logic [SAW-1:0] t_addr;
    logic [SAW-1:0] next_t_addr;
    logic [23:0] io_base;
    logic [23:0] next_io_base;
    logic        m_write;
    logic        next_m_write;
    logic [31:0] m_addr;
    logic [31:0] next_m_addr;
    logic [31:0] m_wdata;
    logic [31:0] next_m_wdata;
    logic [2:0]  tmo;
    logic [2:0]  next_tmo;
    logic        m_pend;
    logic        next_m_pend;
    logic        par_en;
    logic        par_now;
    logic [SAW-1:0] store_addr;
    logic        par_bit;
    logic        xfer;
    logic        hit;
    logic [3:0]  cmd;
    logic        store_wr;
    logic [31:0] store_rd;
    logic [31:0] ad_r;
    logic [3:0]  cbe_r;
    logic        adoe_r;
    logic        cbeoe_r;
    logic [31:0] next_ad;
    logic [3:0]  next_cbe;
    logic        next_adoe;
    logic        next_cbeoe;
    logic [31:0] next_rdata;
    logic        next_done;
    logic        next_abort;
    localparam phb_pkg::phb_state_t // short names for the shared states
        PHB_IDLE   = phb_pkg::PHB_IDLE,   PHB_T_DATA = phb_pkg::PHB_T_DATA,
        PHB_T_TURN = phb_pkg::PHB_T_TURN, PHB_M_ADDR = phb_pkg::PHB_M_ADDR,
        PHB_M_DATA = phb_pkg::PHB_M_DATA, PHB_M_TURN = phb_pkg::PHB_M_TURN;

    assign cmd  = cbe_n_in;
    // data word moves only when both readies sampled low
    assign xfer = !irdy_n_in && !trdy_n_in;
    // io hits by base, configuration hits by idsel alone
    assign hit = ((cmd == phb_pkg::CMD_IO_RD || cmd == phb_pkg::CMD_IO_WR)
                  && ad_in[31:8] == io_base)
        || ((cmd == phb_pkg::CMD_CFG_RD || cmd == phb_pkg::CMD_CFG_WR)
            && idsel);
    phb_store #(.AW(SAW)) u_store (
        .clk   (clk),
        .addr  (store_addr),
        .wr_en (store_wr),
        .be_n  (cbe_n_in),
        .wdata (ad_in),
        .rdata (store_rd)
    );

    // target stores on each completed write data phase
    assign store_wr = (state == PHB_T_DATA) && t_write && xfer;
    assign store_addr = store_wr ? t_addr : next_t_addr; // reads fetch ahead

    // main sequencer, target and master share one engine
    always_comb begin
        next_state   = state;
        next_t_write = t_write;
        next_t_addr  = t_addr;
        next_io_base = io_base;
        next_m_write = m_write;
        next_m_addr  = m_addr;
        next_m_wdata = m_wdata;
        next_tmo     = tmo;
        next_m_pend  = m_pend || mst_start;
        next_rdata   = mst_rdata;
        next_done    = 1'b0;
        next_abort   = 1'b0;
        if (mst_start && !m_pend) begin
            next_m_write = mst_write;
            next_m_addr  = mst_addr;
            next_m_wdata = mst_wdata;
        end
        case (state)
            PHB_IDLE: begin
                // address phase: first clock frame seen low
                if (!frame_n_in && hit) begin
                    next_state   = PHB_T_DATA;
                    next_t_write = cmd[0];
                    next_t_addr  = ad_in[SAW+1:2];
                end else if (m_pend && !gnt_n && frame_n_in
                             && irdy_n_in) begin
                    next_state = PHB_M_ADDR;
                    next_tmo   = '0;
                end
            end
            PHB_T_DATA: begin
                if (xfer) begin
                    next_t_addr = t_addr + 1'b1; // burst advances
                    if (frame_n_in) begin
                        next_state = PHB_T_TURN;
                    end
                end
            end
            PHB_M_ADDR: next_state = PHB_M_DATA;
            PHB_M_DATA: begin
                next_tmo = tmo + 1'b1;
                // devsel tells the master someone answered
                if (!trdy_n_in && !devsel_n_in) begin
                    next_state  = PHB_M_TURN;
                    next_m_pend = 1'b0;
                    next_done   = 1'b1;
                    if (!m_write) begin
                        next_rdata = ad_in;
                    end
                end else if (devsel_n_in
                             && tmo == phb_pkg::DEVSEL_TMO_C) begin
                    next_state  = PHB_M_TURN;
                    next_m_pend = 1'b0;
                    next_abort  = 1'b1;
                end
            end
            default: next_state = PHB_IDLE; // both turnaround states
        endcase
    end

    // bus drive values registered so pins change on clock edges
    always_comb begin
        next_ad    = ad_r;
        next_cbe   = cbe_r;
        next_adoe  = 1'b1;
        next_cbeoe = 1'b1;
        case (next_state)
            PHB_M_ADDR: begin
                next_ad    = next_m_addr;
                next_cbe   = next_m_write ? phb_pkg::CMD_IO_WR
                                          : phb_pkg::CMD_IO_RD;
                next_adoe  = 1'b0;
                next_cbeoe = 1'b0;
            end
            PHB_M_DATA: begin
                next_ad    = m_wdata;
                next_cbe   = 4'h0; // all lanes enabled
                next_adoe  = !m_write;
                next_cbeoe = 1'b0;
            end
            PHB_T_DATA: begin
                next_ad   = store_rd;
                next_adoe = next_t_write; // drive only on reads
            end
            default: next_adoe = 1'b1; // released
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state     <= PHB_IDLE;
            t_write   <= 1'b0;
            t_addr    <= '0;
            io_base   <= phb_pkg::IO_BASE_RST;
            m_write   <= 1'b0;
            m_addr    <= '0;
            m_wdata   <= '0;
            tmo       <= '0;
            m_pend    <= 1'b0;
            mst_rdata <= '0;
            mst_done  <= 1'b0;
            mst_abort <= 1'b0;
            ad_r      <= '0;
            cbe_r     <= 4'hf;
            adoe_r    <= 1'b1;
            cbeoe_r   <= 1'b1;
            par_en    <= 1'b0;
            par_bit   <= 1'b0;
        end else begin
            state     <= next_state;
            t_write   <= next_t_write;
            t_addr    <= next_t_addr;
            io_base   <= next_io_base;
            m_write   <= next_m_write;
            m_addr    <= next_m_addr;
            m_wdata   <= next_m_wdata;
            tmo       <= next_tmo;
            m_pend    <= next_m_pend;
            mst_rdata <= next_rdata;
            mst_done  <= next_done;
            mst_abort <= next_abort;
            ad_r      <= next_ad;
            cbe_r     <= next_cbe;
            adoe_r    <= next_adoe;
            cbeoe_r   <= next_cbeoe;
            par_en    <= !adoe_r; // one clock behind ad
            par_bit   <= par_now;
        end
    end

    phb_parity u_par (
        .ad    (ad_out),
        .cbe_n (cbe_n_out),
        .par   (par_now)
    );

    // parity trails ad by one clock, so it outlives the phase too
    assign par_out  = par_bit;
    assign par_oe_b = !par_en;

    assign ad_out    = (state == PHB_T_DATA && !t_write) ? store_rd : ad_r;
    assign ad_oe_b   = adoe_r;
    assign cbe_n_out = cbeoe_r ? cbe_n_in : cbe_r;
    assign cbe_oe_b  = cbeoe_r;
    // single data phase master: frame only in address clock
    assign frame_n_out = !(state == PHB_M_ADDR);
    assign frame_oe_b  = !(state == PHB_M_ADDR || state == PHB_M_DATA);
    assign irdy_n_out  = !(state == PHB_M_DATA);
    assign irdy_oe_b   = !(state == PHB_M_DATA || state == PHB_M_TURN);
    // target ready at once on writes; on reads only once par_en is set, one clock after ad is driven
    assign trdy_n_out  = !(state == PHB_T_DATA
                           && (t_write || par_en));
    assign trdy_oe_b   = !(state == PHB_T_DATA || state == PHB_T_TURN);
    assign devsel_n_out = !(state == PHB_T_DATA);
    assign devsel_oe_b  = !(state == PHB_T_DATA || state == PHB_T_TURN);
    assign req_n        = !(m_pend && state == PHB_IDLE);
    assign mst_busy     = m_pend;
    // open drain: pull low only in native mode
    assign inta_n_out = 1'b0;
    assign inta_oe_b  = !(native_mode
                          && secondary_drive_interrupt_in);

    // checks
    property p_legacy_quiet;
        @(posedge clk) disable iff (!rst_b)
        !native_mode |-> inta_oe_b;
    endproperty
    a_legacy_quiet: assert property (p_legacy_quiet)
        else $error("interrupt driven in legacy mode");
    property p_par_delay;
        @(posedge clk) disable iff (!rst_b)
        !ad_oe_b |=> !par_oe_b;
    endproperty
    a_par_delay: assert property (p_par_delay)
        else $error("parity not driven after ad");
    property p_par_value;
        @(posedge clk) disable iff (!rst_b)
        !ad_oe_b ##1 1'b1 |-> par_out == ^{$past(ad_out), $past(cbe_n_out)};
    endproperty
    a_par_value: assert property (p_par_value)
        else $error("parity value wrong");
    property p_req_gnt;
        @(posedge clk) disable iff (!rst_b)
        state == PHB_M_ADDR |-> !$past(gnt_n);
    endproperty
    a_req_gnt: assert property (p_req_gnt)
        else $error("master started without grant");
    property p_frame_one;
        @(posedge clk) disable iff (!rst_b)
        !frame_n_out && !frame_oe_b |=> frame_n_out;
    endproperty
    a_frame_one: assert property (p_frame_one)
        else $error("frame held past single phase");
    property p_devsel_hit;
        @(posedge clk) disable iff (!rst_b)
        state == PHB_IDLE && !frame_n_in && hit |=> !devsel_n_out;
    endproperty
    a_devsel_hit: assert property (p_devsel_hit)
        else $error("no devsel after hit");
    c_target: cover property (@(posedge clk) state == PHB_T_DATA && xfer);
    c_mdone: cover property (@(posedge clk) mst_done);
    c_mabort: cover property (@(posedge clk) mst_abort);
endmodule // phb_top

/* shared/phb_pkg.sv */
// phb_pkg: constants and types shared by the host bus interface block
// assumes a 32-bit multiplexed bus sampled on the rising clock edge
package phb_pkg;
    localparam int unsigned AD_W       = 32;
    localparam int unsigned CBE_W      = 4;
    localparam int unsigned BAR_W      = 8;
    // bus command encodings
    localparam logic [3:0]  CMD_IO_RD  = 4'h2;
    localparam logic [3:0]  CMD_IO_WR  = 4'h3;
    localparam logic [3:0]  CMD_MEM_RD = 4'h6;
    localparam logic [3:0]  CMD_MEM_WR = 4'h7;
    localparam logic [3:0]  CMD_CFG_RD = 4'ha;
    localparam logic [3:0]  CMD_CFG_WR = 4'hb;
    // decode window: io base compared on ad[31:8]
    localparam logic [23:0] IO_BASE_RST = 24'h000010;
    // master time-out without a device select answer, in clocks
    localparam int unsigned DEVSEL_TMO  = 5;
    localparam logic [2:0]  DEVSEL_TMO_C = 3'h5;
    localparam logic [7:0]  STORE_DEPTH = 8'h40;
    typedef enum logic [2:0] {
        PHB_IDLE, PHB_T_DATA, PHB_T_TURN, PHB_M_ADDR, PHB_M_DATA,
        PHB_M_TURN
    } phb_state_t;
endpackage

/* logic/phb_store.sv */
// phb_store: small word store reached by target accesses
// assumes one access per clock; read data registered
`timescale 1ns/1ps
module phb_store #(
    parameter int unsigned AW = 6
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] addr,
    input  wire logic          wr_en,
    input  wire logic [3:0]    be_n,
    input  wire logic [31:0]   wdata,
    output logic      [31:0]   rdata
);
    logic [31:0] mem [0:(1<<AW)-1];

    // byte lanes written only where enable is low
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (wr_en && !be_n[i]) begin
                mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
            end
        end
        rdata <= mem[addr];
    end
endmodule // phb_store

/* logic/phb_parity.sv */
// phb_parity: even parity over address/data and command/byte enables
// assumes caller registers the result one clock after the data
`timescale 1ns/1ps
module phb_parity (
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe_n,
    output logic             par
);
    // even parity: xor of all 36 bits
    assign par = ^{ad, cbe_n};
endmodule // phb_parity

/* bench/phb_host.sv */
// phb_host: host bridge, arbiter and far-side target for the bench
// assumes one device on the bus; released control lines pull high
`timescale 1ns/1ps
module phb_host (
    input  wire logic        clk,
    input  wire logic [31:0] ad_out,
    input  wire logic        ad_oe_b,
    input  wire logic [3:0]  cbe_n_out,
    input  wire logic        cbe_oe_b,
    input  wire logic        par_out,
    input  wire logic        par_oe_b,
    input  wire logic        frame_n_out,
    input  wire logic        frame_oe_b,
    input  wire logic        irdy_n_out,
    input  wire logic        irdy_oe_b,
    input  wire logic        trdy_n_out,
    input  wire logic        trdy_oe_b,
    input  wire logic        devsel_n_out,
    input  wire logic        devsel_oe_b,
    input  wire logic        req_n,
    output logic      [31:0] ad_in,
    output logic      [3:0]  cbe_n_in,
    output logic             par_in,
    output logic             frame_n_in,
    output logic             irdy_n_in,
    output logic             trdy_n_in,
    output logic             devsel_n_in,
    output logic             idsel,
    output logic             gnt_n
);
    logic [31:0] h_ad = '0, last = '0, t_adr, t_wd, tgt_word = '0;
    logic [3:0]  h_cbe = 4'hf, t_cmd, t_be;
    logic        h_frame = 1'b1, h_irdy = 1'b1, h_trdy = 1'b1;
    logic        h_devsel = 1'b1, h_par = 1'b0, h_sel = 1'b0;
    logic        h_drv = 1'b0, h_cdrv = 1'b0, h_tdrv = 1'b0, h_pdrv = 1'b0;
    logic        gnt_force = 1'b0, tgt_on = 1'b1;
    int          tgt_dly = 0;

    // grant follows request; forced low only to test reset masking
    assign gnt_n = req_n & !gnt_force;
    assign idsel = h_sel;
    // wired bus: device first, then host, else pull-up or drifting ad
    always_comb begin
        ad_in = !ad_oe_b ? ad_out : h_drv ? h_ad : ~last;
        cbe_n_in = !cbe_oe_b ? cbe_n_out : h_cdrv ? h_cbe : 4'hf;
        par_in = !par_oe_b ? par_out : h_pdrv ? h_par : ~last[0];
        frame_n_in = !frame_oe_b ? frame_n_out : h_cdrv ? h_frame : 1'b1;
        irdy_n_in = !irdy_oe_b ? irdy_n_out : h_cdrv ? h_irdy : 1'b1;
        trdy_n_in = !trdy_oe_b ? trdy_n_out : h_tdrv ? h_trdy : 1'b1;
        devsel_n_in = !devsel_oe_b ? devsel_n_out : h_tdrv ? h_devsel : 1'b1;
    end
    // host parity trails its own ad by one clock
    always @(posedge clk) begin
        h_par <= ^{h_ad, h_cbe};
        h_pdrv <= h_drv;
        last <= ad_in;
    end
    // one single-phase access with the host as initiator
    task automatic cyc(input logic [3:0] cmd, input logic [31:0] adr,
                       input logic [3:0] be, input logic [31:0] wd,
                       input logic sel, input int wt,
                       output logic [31:0] rd, output logic hit);
        hit = 1'b0;
        rd = '0;
        @(posedge clk);
        h_cdrv <= 1'b1;
        h_drv <= 1'b1;
        h_frame <= 1'b0;
        h_ad <= adr;
        h_cbe <= cmd;
        h_sel <= sel;
        @(posedge clk);
        h_frame <= 1'b1;
        h_cbe <= be;
        h_drv <= cmd[0];
        h_ad <= wd;
        h_sel <= 1'b0;
        repeat (wt) @(posedge clk);
        h_irdy <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            hit |= !devsel_n_in;
            if (!irdy_n_in && !trdy_n_in) begin
                rd = ad_in;
                break;
            end
        end
        h_irdy <= 1'b1;
        h_drv <= 1'b0;
        @(posedge clk);
        h_cdrv <= 1'b0;
    endtask
    // far-side target: answers device cycles after tgt_dly clocks
    always begin
        @(posedge clk);
        if (tgt_on && !frame_oe_b && !frame_n_out) begin
            t_cmd = cbe_n_in;
            t_adr = ad_in;
            repeat (tgt_dly) @(posedge clk);
            h_tdrv <= 1'b1;
            h_devsel <= 1'b0;
            h_trdy <= 1'b0;
            h_drv <= !t_cmd[0];
            h_ad <= tgt_word;
            for (int i = 0; i < 16; i++) begin
                @(posedge clk);
                if (!irdy_n_in && !trdy_n_in) break;
            end
            t_wd = ad_in;
            t_be = cbe_n_in;
            h_trdy <= 1'b1;
            h_devsel <= 1'b1;
            h_drv <= 1'b0;
            @(posedge clk);
            h_tdrv <= 1'b0;
        end
    end
endmodule // phb_host

/* bench/testbench.sv */
// testbench: drives the host bus block through the host model
// assumes phb_host stands on the far side of the bus
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_b, ad_oe_b, cbe_oe_b, par_in, par_out, par_oe_b;
    logic        frame_n_in, frame_n_out, frame_oe_b, irdy_n_in, irdy_n_out;
    logic        irdy_oe_b, trdy_n_out, trdy_oe_b, trdy_n_in, devsel_n_in;
    logic        devsel_n_out, devsel_oe_b, idsel, req_n, gnt_n, inta_n;
    logic        inta_n_out, inta_oe_b, native_mode, mst_start, mst_write;
    logic        mst_busy, mst_done, mst_abort, secondary_drive_interrupt_in;
    logic [31:0] ad_in, ad_out, mst_addr, mst_wdata, mst_rdata, p_ad;
    logic [3:0]  cbe_n_in, cbe_n_out, p_cbe;
    logic        p_drv = 1'b1;
    int          num_errors = 0, total_checks = 0;

    phb_top #(.SAW(6)) i_phb_top (.*);
    phb_host i_phb_host (.*);
    assign inta_n = inta_oe_b ? 1'b1 : inta_n_out; // open drain pull-up

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // device parity must trail whatever it put on ad by one clock
    always @(posedge clk) begin
        if (rst_b && !p_drv) begin
            check(par_oe_b, 1'b0);
            check(par_out, ^{p_ad, p_cbe});
        end
        p_drv <= ad_oe_b;
        p_ad <= ad_in;
        p_cbe <= cbe_n_in;
    end
    task automatic check_idle();
        check({ad_oe_b, cbe_oe_b, par_oe_b, frame_oe_b, irdy_oe_b,
               trdy_oe_b, devsel_oe_b, req_n}, 8'hff);
    endtask
    // target: full write, byte-masked write, read with waits
    task automatic t_target();
        logic [31:0] rd;
        logic        hit;
        i_phb_host.cyc(phb_pkg::CMD_IO_WR, 32'h00001004, 4'h0,
                       32'h12345678, 1'b0, 0, rd, hit);
        check(hit, 1'b1);
        i_phb_host.cyc(phb_pkg::CMD_IO_WR, 32'h00001004, 4'ha,
                       32'haabbccdd, 1'b0, 1, rd, hit);
        i_phb_host.cyc(phb_pkg::CMD_IO_RD, 32'h00001004, 4'h0,
                       32'h0, 1'b0, 2, rd, hit);
        check(rd, 32'h12bb56dd);
    endtask
    task automatic probe(input logic [3:0] cmd, input logic [31:0] adr,
                         input logic sel, input logic exp);
        logic [31:0] rd;
        logic        hit;
        i_phb_host.cyc(cmd, adr, 4'hf, 32'h0, sel, 0, rd, hit);
        check(hit, exp);
    endtask
    // address decode: window edges, config select, other spaces
    task automatic t_decode();
        probe(phb_pkg::CMD_IO_RD, 32'h000011fc, 1'b0, 1'b0);
        probe(phb_pkg::CMD_IO_RD, 32'h00000ffc, 1'b0, 1'b0);
        probe(phb_pkg::CMD_CFG_RD, 32'h00000000, 1'b1, 1'b1);
        probe(phb_pkg::CMD_CFG_RD, 32'h00000000, 1'b0, 1'b0);
        probe(phb_pkg::CMD_CFG_WR, 32'h00000000, 1'b1, 1'b1);
        probe(phb_pkg::CMD_MEM_RD, 32'h00001000, 1'b0, 1'b0);
    endtask
    // device as master; on = 0 leaves the cycle unanswered
    task automatic t_master(input logic wr, input int dly, input logic on);
        int          nfr;
        logic        sreq;
        nfr = 0;
        sreq = 1'b0;
        i_phb_host.tgt_dly = dly;
        i_phb_host.tgt_on = on;
        i_phb_host.tgt_word = 32'h5a0fc396;
        @(posedge clk);
        mst_write <= wr;
        mst_addr <= 32'h00003008;
        mst_wdata <= 32'h9e3779b9;
        mst_start <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            mst_start <= 1'b0;
            sreq |= !req_n;
            if (!frame_oe_b && !frame_n_out) nfr++;
            if (mst_done || mst_abort) break;
        end
        check(sreq, 1'b1);
        check(mst_busy, 1'b0);
        check(nfr, 1);
        check({mst_done, mst_abort}, {on, !on});
        if (on) begin
            check(i_phb_host.t_adr, 32'h00003008);
            check(i_phb_host.t_cmd, wr ? phb_pkg::CMD_IO_WR
                                       : phb_pkg::CMD_IO_RD);
            if (wr) check(i_phb_host.t_wd, 32'h9e3779b9);
            if (wr) check(i_phb_host.t_be, 4'h0);
            if (!wr) check(mst_rdata, 32'h5a0fc396);
        end
        i_phb_host.tgt_on = 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // interrupt only when native mode and the drive asks
    task automatic t_irq();
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            native_mode <= m[0];
            secondary_drive_interrupt_in <= m[1];
            repeat (3) @(posedge clk);
            check(inta_n, !(m[0] && m[1]));
        end
    endtask
    // grant and request held during a second reset must be ignored
    task automatic t_reset_grant();
        @(posedge clk);
        rst_b <= 1'b0;
        mst_start <= 1'b1;
        i_phb_host.gnt_force <= 1'b1;
        repeat (4) begin
            @(posedge clk);
            check({req_n, frame_oe_b}, 2'h3);
        end
        mst_start <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        i_phb_host.gnt_force <= 1'b0;
        @(posedge clk);
        check_idle();
    endtask
    // watchdog: well beyond the few hundred clocks the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        rst_b = 1'b0;
        native_mode = 1'b0;
        secondary_drive_interrupt_in = 1'b0;
        mst_start = 1'b0;
        mst_write = 1'b0;
        mst_addr = '0;
        mst_wdata = '0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check_idle();
        t_target();
        t_decode();
        t_master(1'b1, 0, 1'b1);
        t_master(1'b1, 2, 1'b1);
        t_master(1'b0, 1, 1'b1);
        t_master(1'b0, 3, 1'b1);
        t_master(1'b1, 0, 1'b0);
        t_irq();
        t_reset_grant();
        stop_test();
    end
endmodule // testbench
